// >>> verif/afecps_sensor_model.sv
// behavioural line sensor that strobes a reference then a data sample into the front end
`timescale 1ns/1ps
`default_nettype none
module afecps_sensor_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [3:0][15:0] ref_level,
    input wire logic [3:0][15:0] data_level,
    output logic reference_sample_pulse,
    output logic data_sample_pulse,
    output logic [3:0][15:0] adc_sample
);
    logic [2:0] step; // pixel phase, 0 while idle
    // one pixel period: reference strobe, a gap, then the data strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step <= 3'h0;
            reference_sample_pulse <= 1'b0;
            data_sample_pulse <= 1'b0;
            adc_sample <= '0;
        end else begin
            reference_sample_pulse <= 1'b0;
            data_sample_pulse <= 1'b0;
            // between strobes the lines keep moving, so a stale value never looks valid
            adc_sample <= ~adc_sample;
            step <= go ? 3'h1 : ((step != 3'h0 && step < 3'h4) ? step + 3'h1 : 3'h0);
            if (step == 3'h1) begin // reference interval comes first
                reference_sample_pulse <= 1'b1;
                adc_sample <= ref_level;
            end
            if (step == 3'h3) begin // gap keeps the two strobes apart
                data_sample_pulse <= 1'b1;
                adc_sample <= data_level;
            end
        end
    end
endmodule : afecps_sensor_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the channel and pin select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, internal_line_sync = 1'b1, line_sync_pin_in = 1'b0, line_sync_pin_out, line_sync_pin_oe;
    logic line_sync_active, shared_pin_a_in = 1'b1, shared_pin_a_out, shared_pin_a_oe, shared_pin_a_pulldown;
    logic serial_data_out = 1'b0, shared_pin_b_in = 1'b0, shared_pin_b_out, shared_pin_b_oe, shared_pin_b_pulldown;
    logic storage_pulse_out = 1'b0, reference_sample_pulse, data_sample_pulse, parallel_mode, go = 1'b0;
    logic [3:0][15:0] adc_sample;
    logic [3:0] channel_standby, channel_sampling_mode, channel_input_polarity;
    logic [7:0] out_pins;
    int fails = 0, checks_done = 0;
    // ch2 reference differs from zero to prove it is ignored in single sampling
    logic [3:0][15:0] ref_lv = {16'h0, 16'h5555, 16'h0, 16'h0100};
    logic [3:0][15:0] dat_lv = {16'h6666, 16'h2152, 16'h7777, 16'h1234};
    always #2.5 clk = ~clk;
    afecps_top DUT (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .internal_line_sync, .line_sync_pin_in, .line_sync_pin_out, .line_sync_pin_oe,
        .line_sync_active, .shared_pin_a_in, .shared_pin_a_out, .shared_pin_a_oe, .shared_pin_a_pulldown,
        .serial_data_out, .shared_pin_b_in, .shared_pin_b_out, .shared_pin_b_oe, .shared_pin_b_pulldown,
        .storage_pulse_out, .reference_sample_pulse, .data_sample_pulse, .adc_sample, .channel_standby,
        .channel_sampling_mode, .channel_input_polarity, .parallel_mode, .out_pins);
    afecps_sensor_model SENSOR (.clk, .rst, .go, .ref_level(ref_lv), .data_level(dat_lv),
        .reference_sample_pulse, .data_sample_pulse, .adc_sample);
    // verdict and end of run, also reached by a timeout
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // compare seen against expected, four-state exact
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one classic wishbone cycle; held until ack is sampled high
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin // no answer: count it and stop
            fails++;
            give_verdict();
        end
    endtask : wb
    // defaults after reset, plus an unmapped read
    task t_reset;
        wb(1'b0, 8'h00, 32'h0); check(rd, 32'h0);
        wb(1'b0, 8'h04, 32'h0); check(rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0); check(rd, 32'h0); // unmapped reads as zero
        wb(1'b0, 8'h0C, 32'h0); check(rd, 32'h0000_0F11);
        check({line_sync_pin_oe, line_sync_pin_out}, 2'h3);
        internal_line_sync <= 1'b0;
        @(posedge clk);
        check({line_sync_pin_oe, line_sync_pin_out}, 2'h2);
        internal_line_sync <= 1'b1;
        check({shared_pin_a_pulldown, shared_pin_b_pulldown}, 2'h3);
    endtask : t_reset
    // external line sync with both polarities
    task t_sync;
        line_sync_pin_in <= 1'b1;
        wb(1'b1, 8'h00, 32'h1);
        repeat (3) @(posedge clk);
        check({line_sync_pin_oe, line_sync_active}, 2'h1);
        wb(1'b1, 8'h00, 32'h3);
        check(line_sync_active, 1'b0);
        line_sync_pin_in <= 1'b0;
        repeat (3) @(posedge clk);
        check(line_sync_active, 1'b1);
    endtask : t_sync
    // every function code of both shared pins
    task t_pins;
        wb(1'b1, 8'h08, 32'h3);
        serial_data_out <= 1'b1; // pin a alternate shows 1, pin b alternate shows 0
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, 8'h00, 32'(c * 20));
            check({shared_pin_a_oe, shared_pin_a_pulldown}, {c[0], c == 0});
            check({shared_pin_b_oe, shared_pin_b_pulldown}, {c[0], c == 0});
            if (c[0]) check({shared_pin_a_out, shared_pin_b_out}, (c == 1) ? 2'h3 : 2'h2);
            if (c == 2) begin
                wb(1'b0, 8'h0C, 32'h0); check(rd, 32'h0000_0F14); // test input levels
            end
        end
    endtask : t_pins
    // channel count codes and per-channel mode and polarity bits
    task t_chan;
        wb(1'b1, 8'h00, 32'h00); check(channel_standby, 4'h0);
        wb(1'b1, 8'h00, 32'h40); check(channel_standby, 4'h8);
        wb(1'b1, 8'h00, 32'h80); check(channel_standby, 4'hA);
        wb(1'b1, 8'h00, 32'hC0); check(channel_standby, 4'h0); // reserved code
        wb(1'b1, 8'h04, 32'hFFFF_FFA5);
        wb(1'b0, 8'h04, 32'h0); check(rd, 32'h0000_00A5);
        check(channel_sampling_mode, 4'h5);
        check(channel_input_polarity, 4'hA);
    endtask : t_chan
    // two-channel pixel: ch0 double sampling, ch2 single, in parallel mode
    task t_pixel;
        logic [7:0] got [$];
        wb(1'b1, 8'h04, 32'h04);
        wb(1'b1, 8'h00, 32'h180);
        check(parallel_mode, 1'b1);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (40) begin
            @(posedge clk);
            if (out_pins !== 8'h00 && out_pins !== 8'hAA) got.push_back(out_pins);
        end
        check(got.size(), 4); // standby channels stay out
        if (got.size() == 4) begin
            check({got[0], got[1]}, 16'h1134); // data minus reference
            check({got[2], got[3]}, 16'h2152); // reference ignored
        end
    endtask : t_pixel
    // serial mode: framing marks on lanes b and c, pixel bits msb first on lane a
    task t_serial;
        int nb, nc, nbits;
        logic pb, pc;
        logic [31:0] sh;
        nb = 0;
        nc = 0;
        nbits = 0;
        sh = 32'h0;
        wb(1'b1, 8'h00, 32'h080);
        wb(1'b1, 8'h04, 32'h14); // ch0 inverted polarity, ch2 single sampling
        check(parallel_mode, 1'b0);
        pb = out_pins[2];
        pc = out_pins[4];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (80) begin
            @(posedge clk);
            nb += (out_pins[2] === 1'b1 && pb === 1'b0);
            nc += (out_pins[4] === 1'b1 && pc === 1'b0);
            pb = out_pins[2];
            pc = out_pins[4];
            // a byte mark opens an eight-bit capture window on lane a
            if (out_pins[2] === 1'b1) nbits = 8;
            if (nbits > 0) begin
                sh = {sh[30:0], out_pins[0]};
                nbits--;
            end
        end
        check(nb, 4); // one mark per byte
        check(nc, 2); // one mark per pixel
        check(sh, 32'hEECC_2152); // reference minus data on ch0, then ch2
    endtask : t_serial
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_sync();
        t_pins();
        t_chan();
        t_pixel();
        t_serial();
        give_verdict();
    end
endmodule : tb
`default_nettype wire

// >>> verilog/afecps_defines.svh
// register offsets, field positions and reset codes of the channel and pin select block
`ifndef AFECPS_DEFINES_SVH
`define AFECPS_DEFINES_SVH
// register byte offsets
`define AFECPS_CTRL_OFS 8'h00
`define AFECPS_CHAN_OFS 8'h04
`define AFECPS_GPO_OFS 8'h08
`define AFECPS_STAT_OFS 8'h0C
// control register fields
`define AFECPS_CTRL_SYNC_DIR 0
`define AFECPS_CTRL_SYNC_POL 1
`define AFECPS_CTRL_PIN_A_LO 2
`define AFECPS_CTRL_PIN_B_LO 4
`define AFECPS_CTRL_CNT_LO 6
`define AFECPS_CTRL_PAR_MODE 8
`define AFECPS_CTRL_RESET 32'h0000_0000
`define AFECPS_CTRL_MASK 32'h0000_01FF
// channel register fields: sampling mode bits then polarity bits
`define AFECPS_CHAN_MODE_LO 0
`define AFECPS_CHAN_POL_LO 4
`define AFECPS_CHAN_RESET 32'h0000_0000
`define AFECPS_CHAN_MASK 32'h0000_00FF
// general output register
`define AFECPS_GPO_RESET 32'h0000_0000
`define AFECPS_GPO_MASK 32'h0000_0003
// status register fields
`define AFECPS_STAT_GENERAL_INPUT_1 0
`define AFECPS_STAT_GENERAL_INPUT_3 1
`define AFECPS_STAT_TEST_A 2
`define AFECPS_STAT_TEST_B 3
`define AFECPS_STAT_SYNC 4
`define AFECPS_STAT_BUSY 5
`define AFECPS_STAT_ACT_LO 8
`define AFECPS_STAT_PEND_LO 12
// data path sizes
`define AFECPS_NUM_CH 4
`define AFECPS_SAMPLE_W 16
`endif

// >>> verilog/afecps_pkg.sv
// types shared by the channel and pin select block
package afecps_pkg;
    // shared pin function codes
    typedef enum logic [1:0] {
        PF_GP_IN = 2'h0,
        PF_GP_OUT = 2'h1,
        PF_TEST = 2'h2,
        PF_ALT = 2'h3
    } afecps_pin_func_t;
    // channel count codes
    typedef enum logic [1:0] {
        CC_FOUR = 2'h0,
        CC_THREE = 2'h1,
        CC_TWO = 2'h2,
        CC_RSVD = 2'h3
    } afecps_ch_count_t;
    // output sequencer states, one-hot
    typedef enum logic [2:0] {
        SQ_IDLE = 3'h1,
        SQ_LOAD = 3'h2,
        SQ_SEND = 3'h4
    } afecps_seq_state_t;
endpackage : afecps_pkg

// >>> verilog/afecps_top.sv
// channel and pin select logic of a four-channel sensor front end, with wishbone registers
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "afecps_defines.svh"
module afecps_top
    import afecps_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic internal_line_sync,
    input wire logic line_sync_pin_in,
    output logic line_sync_pin_out,
    output logic line_sync_pin_oe,
    output logic line_sync_active,
    input wire logic shared_pin_a_in,
    output logic shared_pin_a_out,
    output logic shared_pin_a_oe,
    output logic shared_pin_a_pulldown,
    input wire logic serial_data_out,
    input wire logic shared_pin_b_in,
    output logic shared_pin_b_out,
    output logic shared_pin_b_oe,
    output logic shared_pin_b_pulldown,
    input wire logic storage_pulse_out,
    input wire logic reference_sample_pulse,
    input wire logic data_sample_pulse,
    input wire logic [3:0][15:0] adc_sample,
    output logic [3:0] channel_standby,
    output logic [3:0] channel_sampling_mode,
    output logic [3:0] channel_input_polarity,
    output logic parallel_mode,
    output logic [7:0] out_pins
);
    // software registers
    logic [31:0] ctrl_reg; // sync, pin functions, channel count, output mode
    logic [31:0] chan_reg; // per-channel sampling mode and polarity
    logic [31:0] gpo_reg; // general outputs 1 and 3
    logic line_sync_dir_select;
    logic line_sync_polarity;
    afecps_pin_func_t shared_pin_a_function;
    afecps_pin_func_t shared_pin_b_function;
    afecps_ch_count_t channel_count_select;
    logic general_output_1;
    logic general_output_3;
    // pin synchronisers: first stage feeds only the second
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    // data path
    logic [15:0] ref_hold [4]; // reference sample per channel
    logic [15:0] pixel [4]; // conversion result per channel
    logic [3:0] active_mask;
    logic [3:0] pending; // channels waiting to be sent
    afecps_seq_state_t state;
    logic [1:0] cur_ch;
    logic [15:0] word;
    logic [7:0] byte_reg;
    logic hi_byte;
    logic [2:0] bit_cnt;
    logic byte_done;
    logic [3:0] pend_clr;
    logic [7:0] next_pins;
    logic wb_req;
    logic [31:0] stat_word;

    // merge written byte lanes into a register value
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] din,
                                            input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : wb_merge

    // active channels for a channel count code
    function automatic logic [3:0] count_to_mask(input afecps_ch_count_t code);
        logic [3:0] m;
        m = 4'hF;
        unique case (code)
            CC_FOUR: m = 4'hF;
            CC_THREE: m = 4'h7;
            CC_TWO: m = 4'h5;
            CC_RSVD: m = 4'hF; // reserved code keeps all inputs running
        endcase
        return m;
    endfunction : count_to_mask

    // pixel value: difference in double sampling, data alone in single, sign by polarity
    function automatic logic [15:0] pixel_calc(input logic [15:0] dat, input logic [15:0] rf,
                                               input logic sh, input logic pol);
        logic [15:0] base;
        logic [15:0] diff;
        base = sh ? 16'h0000 : rf;
        diff = pol ? 16'(base - dat) : 16'(dat - base);
        return diff;
    endfunction : pixel_calc

    // register fields
    assign line_sync_dir_select = ctrl_reg[`AFECPS_CTRL_SYNC_DIR];
    assign line_sync_polarity = ctrl_reg[`AFECPS_CTRL_SYNC_POL];
    assign shared_pin_a_function = afecps_pin_func_t'(ctrl_reg[`AFECPS_CTRL_PIN_A_LO +: 2]);
    assign shared_pin_b_function = afecps_pin_func_t'(ctrl_reg[`AFECPS_CTRL_PIN_B_LO +: 2]);
    assign channel_count_select = afecps_ch_count_t'(ctrl_reg[`AFECPS_CTRL_CNT_LO +: 2]);
    assign parallel_mode = ctrl_reg[`AFECPS_CTRL_PAR_MODE];
    assign channel_sampling_mode = chan_reg[`AFECPS_CHAN_MODE_LO +: 4];
    assign channel_input_polarity = chan_reg[`AFECPS_CHAN_POL_LO +: 4];
    assign general_output_1 = gpo_reg[0];
    assign general_output_3 = gpo_reg[1];
    assign active_mask = count_to_mask(channel_count_select);
    assign channel_standby = ~active_mask;

    // bus request seen while ack is low; ack answers one edge later
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ack generation, dropped the cycle after it was given
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // register writes take effect at the request edge; unmapped writes are dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `AFECPS_CTRL_RESET;
            chan_reg <= `AFECPS_CHAN_RESET;
            gpo_reg <= `AFECPS_GPO_RESET;
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i == `AFECPS_CTRL_OFS) begin
                ctrl_reg <= wb_merge(ctrl_reg, wb_dat_i, wb_sel_i, `AFECPS_CTRL_MASK);
            end
            if (wb_adr_i == `AFECPS_CHAN_OFS) begin
                chan_reg <= wb_merge(chan_reg, wb_dat_i, wb_sel_i, `AFECPS_CHAN_MASK);
            end
            if (wb_adr_i == `AFECPS_GPO_OFS) begin
                gpo_reg <= wb_merge(gpo_reg, wb_dat_i, wb_sel_i, `AFECPS_GPO_MASK);
            end
        end
    end

    // status word built from live pin and sequencer state
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`AFECPS_STAT_GENERAL_INPUT_1] = (shared_pin_a_function == PF_GP_IN) && pin_sync[1];
        stat_word[`AFECPS_STAT_GENERAL_INPUT_3] = (shared_pin_b_function == PF_GP_IN) && pin_sync[2];
        stat_word[`AFECPS_STAT_TEST_A] = (shared_pin_a_function == PF_TEST) && pin_sync[1];
        stat_word[`AFECPS_STAT_TEST_B] = (shared_pin_b_function == PF_TEST) && pin_sync[2];
        stat_word[`AFECPS_STAT_SYNC] = line_sync_active;
        stat_word[`AFECPS_STAT_BUSY] = (state != SQ_IDLE);
        stat_word[`AFECPS_STAT_ACT_LO +: 4] = active_mask;
        stat_word[`AFECPS_STAT_PEND_LO +: 4] = pending;
    end

    // read data registered with the ack; unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                `AFECPS_CTRL_OFS: wb_dat_o <= ctrl_reg;
                `AFECPS_CHAN_OFS: wb_dat_o <= chan_reg;
                `AFECPS_GPO_OFS: wb_dat_o <= gpo_reg;
                `AFECPS_STAT_OFS: wb_dat_o <= stat_word;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // two-flop synchronisers for the three pin inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {shared_pin_b_in, shared_pin_a_in, line_sync_pin_in};
            pin_sync <= pin_meta;
        end
    end

    // line-sync pin: drive internal sync by default, else take external sync
    assign line_sync_pin_oe = !line_sync_dir_select;
    assign line_sync_pin_out = line_sync_dir_select ? 1'b0 : internal_line_sync;
    // external level inverted when polarity is set; internal sync used when driving
    assign line_sync_active = line_sync_dir_select ? (pin_sync[0] ^ line_sync_polarity)
                                                   : internal_line_sync;

    // shared pin a: pull-down only while it is a general input
    always_comb begin
        shared_pin_a_out = 1'b0;
        shared_pin_a_oe = 1'b0;
        shared_pin_a_pulldown = 1'b0;
        unique case (shared_pin_a_function)
            PF_GP_IN: shared_pin_a_pulldown = 1'b1;
            PF_GP_OUT: begin
                shared_pin_a_oe = 1'b1;
                shared_pin_a_out = general_output_1;
            end
            PF_TEST: shared_pin_a_oe = 1'b0; // test input, read back only
            PF_ALT: begin
                shared_pin_a_oe = 1'b1;
                shared_pin_a_out = serial_data_out;
            end
        endcase
    end

    // shared pin b: same scheme, alternate function is the storage pulse
    always_comb begin
        shared_pin_b_out = 1'b0;
        shared_pin_b_oe = 1'b0;
        shared_pin_b_pulldown = 1'b0;
        unique case (shared_pin_b_function)
            PF_GP_IN: shared_pin_b_pulldown = 1'b1;
            PF_GP_OUT: begin
                shared_pin_b_oe = 1'b1;
                shared_pin_b_out = general_output_3;
            end
            PF_TEST: shared_pin_b_oe = 1'b0;
            PF_ALT: begin
                shared_pin_b_oe = 1'b1;
                shared_pin_b_out = storage_pulse_out;
            end
        endcase
    end

    // sampling: reference on its pulse (double sampling only), result on the data pulse;
    // a reference pulse landing with the data pulse is the software's fault; it still loads ref_hold and that pixel uses the previous reference
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < 4; c++) begin
                ref_hold[c] <= 16'h0000;
                pixel[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (reference_sample_pulse && !channel_sampling_mode[c]) begin
                    ref_hold[c] <= adc_sample[c];
                end
                if (data_sample_pulse) begin
                    pixel[c] <= pixel_calc(adc_sample[c], ref_hold[c],
                                           channel_sampling_mode[c], channel_input_polarity[c]);
                end
            end
        end
    end

    // a byte ends after one cycle in parallel mode or eight bits in serial mode
    assign byte_done = parallel_mode || (bit_cnt == 3'h7);

    // lowest pending channel is cleared when it is loaded
    always_comb begin
        pend_clr = 4'h0;
        if (state == SQ_LOAD) begin
            pend_clr[cur_ch] = 1'b1;
        end
    end

    // pending set on each data pulse for active channels only; set beats clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= 4'h0;
        end else begin
            pending <= (pending & ~pend_clr) | (data_sample_pulse ? active_mask : 4'h0);
        end
    end

    // output sequencer: each active pixel leaves as high byte then low byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SQ_IDLE;
            cur_ch <= 2'h0;
            word <= 16'h0000;
            byte_reg <= 8'h00;
            hi_byte <= 1'b0;
            bit_cnt <= 3'h0;
        end else begin
            unique case (state)
                SQ_IDLE: begin
                    if (pending != 4'h0) begin
                        state <= SQ_LOAD;
                        cur_ch <= pending[0] ? 2'h0 : pending[1] ? 2'h1 : pending[2] ? 2'h2 : 2'h3;
                    end
                end
                SQ_LOAD: begin
                    word <= pixel[cur_ch];
                    byte_reg <= pixel[cur_ch][15:8];
                    hi_byte <= 1'b1;
                    bit_cnt <= 3'h0;
                    state <= SQ_SEND;
                end
                SQ_SEND: begin
                    if (byte_done) begin
                        bit_cnt <= 3'h0;
                        if (hi_byte) begin
                            hi_byte <= 1'b0;
                            byte_reg <= word[7:0];
                        end else begin
                            state <= SQ_IDLE;
                        end
                    end else begin
                        bit_cnt <= 3'(bit_cnt + 3'h1);
                        byte_reg <= {byte_reg[6:0], 1'b0}; // serial mode shifts msb first
                    end
                end
            endcase
        end
    end

    // pin map: parallel puts the byte on bits 0-7; serial drives lane pairs, clock pair on 6/7
    always_comb begin
        next_pins = 8'h00;
        if (state == SQ_SEND) begin
            if (parallel_mode) begin
                next_pins = byte_reg;
            end else begin
                next_pins[1:0] = {~byte_reg[7], byte_reg[7]}; // lane a: data bit
                next_pins[3:2] = {~(bit_cnt == 3'h0), (bit_cnt == 3'h0)}; // lane b: byte start
                next_pins[5:4] = {~(hi_byte && bit_cnt == 3'h0), hi_byte && bit_cnt == 3'h0}; // lane c
                next_pins[7:6] = {bit_cnt[0], ~bit_cnt[0]};
            end
        end else if (!parallel_mode) begin
            next_pins = 8'hAA; // idle differential: positive low, negative high
        end
    end

    // output pins come from flops, one cycle behind the sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_pins <= 8'h00;
        end else begin
            out_pins <= next_pins;
        end
    end

    a_sync_drive: assert property (@(posedge clk) disable iff (rst)
        !line_sync_dir_select |-> line_sync_pin_oe && line_sync_pin_out == internal_line_sync)
        else $error("line sync not driven from internal sync");
    a_sync_input: assert property (@(posedge clk) disable iff (rst)
        line_sync_dir_select && $past(line_sync_dir_select, 2) && $past(line_sync_polarity, 2)
            == line_sync_polarity |-> !line_sync_pin_oe
            && line_sync_active == ($past(line_sync_pin_in, 2) ^ line_sync_polarity))
        else $error("external line sync level wrong");
    a_pin_a_map: assert property (@(posedge clk) disable iff (rst)
        (shared_pin_a_function == PF_GP_OUT |-> shared_pin_a_oe && shared_pin_a_out == general_output_1)
        and (shared_pin_a_function == PF_GP_IN |-> !shared_pin_a_oe && shared_pin_a_pulldown))
        else $error("shared pin a function wrong");
    a_pin_b_map: assert property (@(posedge clk) disable iff (rst)
        shared_pin_b_function == PF_ALT |-> shared_pin_b_oe && shared_pin_b_out == storage_pulse_out
            && !shared_pin_b_pulldown)
        else $error("shared pin b storage pulse wrong");
    a_standby_map: assert property (@(posedge clk) disable iff (rst)
        channel_count_select == CC_TWO |-> channel_standby == 4'hA)
        else $error("two-channel standby map wrong");
    a_cds_diff: assert property (@(posedge clk) disable iff (rst)
        data_sample_pulse && !channel_sampling_mode[0] && !channel_input_polarity[0]
            |=> pixel[0] == 16'($past(adc_sample[0][15:0]) - $past(ref_hold[0])))
        else $error("double sampling result not data minus reference");
    a_sh_single: assert property (@(posedge clk) disable iff (rst)
        reference_sample_pulse && channel_sampling_mode[1] |=> $stable(ref_hold[1]))
        else $error("reference sampled in single mode");
    a_seq_active: assert property (@(posedge clk) disable iff (rst)
        data_sample_pulse && channel_count_select == CC_THREE |=> !pending[3] || $past(pending[3]))
        else $error("standby channel queued for output");
    a_par_bytes: assert property (@(posedge clk) disable iff (rst)
        state == SQ_SEND && parallel_mode |=> out_pins == $past(byte_reg))
        else $error("parallel byte not on data pins");
endmodule : afecps_top
`default_nettype wire
